// ===== dcp_cfg.svh
// Purpose: constants of the disk controller phase and DMA FIFO block
// Assumes: APB byte addresses, 25 MHz pclk
// Notes: offsets, fields, command and status codes, limits
//
// Overview of operation
// R01: Third mode: DMA enable bit gates DMA and interrupt; density low.
// R02: Single or burst DMA; burst when config F0 bit 1 set.
// R03: DMA enabled by Specify; device raises request itself.
// R04: After any reset enter command phase; bytes in fixed order.
// R05: Host writes only when request flag 1 and direction 0.
// R06: Request flag drops per write, rises per further parameter.
// R07: After final parameter request flag stays 0; phase advances.
// R08: FIFO kept disabled during command phase.
// R09: Out of reset FIFO disabled, one byte per DMA cycle.
// R10: Threshold equals programmed parameter plus one, 1 to 16.
// R11: Execution data moves only by DMA, both directions.
// R12: Disk read: request at 16 minus threshold or sector end; code forces it only at the sector end that ends the transfer.
// R13: Disk read: DMA reads FIFO; request drops when FIFO empty.
// R14: Disk write: request on execution entry, held until full.
// R15: Disk write: request again when free space reaches threshold.
// R16: Terminal count ends the DMA transfer.
// R17: Ends on count, overrun, underrun or last sector number.
// R18: Host stall completes sector; implicit ends report abnormal.
// R19: Host tolerates request lag while FIFO drains.
// R20: Result phase starts with interrupt; all results read first.
// R21: Host reads results only when both flags read 1.
// R22: After last result: request 1, direction 0, busy cleared.
// R23: Invalid first byte raises interrupt; Sense reports it.
// R24: Mode chosen by config F0 bits 3 and 2.
// R25: Pin reset sets reset bit; core held until host clears it.
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH
`define DCP_OFS_MSR   8'h00
`define DCP_OFS_DATA  8'h04
`define DCP_OFS_DOR   8'h08
`define DCP_OFS_CFG   8'h0C
`define DCP_DOR_RST   2
`define DCP_DOR_DMA   3
`define DCP_DOR_HD    5
`define DCP_CFG_BURST 1
`define DCP_CFG_MODE  3:2
`define DCP_CNF_NOFIFO 5
`define DCP_CMD_SPEC  8'h03
`define DCP_CMD_CONF  8'h13
`define DCP_CMD_READ  8'h06
`define DCP_CMD_WRITE 8'h05
`define DCP_CMD_SENSE 8'h08
`define DCP_ST0_ABN   8'h40
`define DCP_ST0_INV   8'h80
`define DCP_SECT_LAST 8'h7F
`define DCP_FIFO_DEPTH 5'h10
`endif

// ===== dcp_pkg.sv
// Purpose: types of the disk controller phase block
// Assumes: nothing
// Notes: whole block state is one packed struct
package dcp_pkg;
   typedef enum logic [1:0] {
      DCP_PH_CMD,
      DCP_PH_PARAM,
      DCP_PH_EXEC,
      DCP_PH_RESULT
   } dcp_phase_e;
   typedef enum logic [1:0] {
      DCP_MODE_AT,
      DCP_MODE_PS2,
      DCP_MODE_M30,
      DCP_MODE_RSV
   } dcp_mode_e;
   typedef struct packed {
      dcp_phase_e        phase;
      logic [7:0]        cmd;
      logic [7:0]        lat;
      logic              pidx;
      logic              proc;
      logic              request_for_master_flag;
      logic              transfer_direction_flag;
      logic              busy;
      logic              dma_spec;
      logic              fifo_en;
      logic [3:0]        thr;
      logic [7:0]        last_sector_number;
      logic [7:0]        sector;
      logic [7:0]        bcnt;
      logic              dir_wr;
      logic              tc_seen;
      logic              ovr;
      logic              abn;
      logic              pad;
      logic              xfer_on;
      logic              rd_last;
      logic              arm;
      logic              gap;
      logic              inv_pend;
      logic              int_pend;
      logic [7:0]        st0;
      logic [4:0]        fcnt;
      logic [3:0]        wp;
      logic [3:0]        rp;
      logic [15:0][7:0]  mem;
      logic [2:0][7:0]   rbuf;
      logic [1:0]        rcnt;
      logic [1:0]        ridx;
      logic              dor_rst;
      logic              dor_dma;
      logic              dor_hd;
      dcp_mode_e         mode;
      logic              burst;
      logic              dma_req;
      logic [7:0]        dma_rdata;
      logic              int_req;
      logic              dens;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
      logic [7:0]        wr_data;
   } dcp_state_s;
endpackage : dcp_pkg

// ===== dcp_top.sv
// Purpose: command, execution and result phases with DMA FIFO
// Assumes: DMA and disk byte strobes synchronous to pclk
// Notes: registers reached over APB, one wait state
`include "dcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dcp_top
   import dcp_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             dma_req,
   input  wire logic        dma_ack,
   input  wire logic [7:0]  dma_wdata,
   output logic      [7:0]  dma_rdata,
   input  wire logic        transfer_end_strobe,
   output logic             int_req,
   output logic             density_select,
   input  wire logic        disk_rd_valid,
   input  wire logic [7:0]  disk_rd_data,
   output logic             disk_rd_active,
   output logic             disk_wr_active,
   input  wire logic        disk_wr_take,
   output logic      [7:0]  disk_wr_data
);

   localparam dcp_state_s ST_RST = '{
      phase:    DCP_PH_CMD,
      mode:     DCP_MODE_AT,
      dor_rst:  1'b1,
      dma_spec: 1'b1,
      default:  '0
   };

   dcp_state_s st_ff;
   dcp_state_s nxt_st;

   logic apb_acc;
   logic apb_take;
   assign apb_acc  = psel & penable;
   assign apb_take = psel & penable & st_ff.pready;

   function automatic logic [4:0] fifo_cap(input logic en);
      fifo_cap = en ? `DCP_FIFO_DEPTH : 5'h01;
   endfunction : fifo_cap

   function automatic logic dma_gate(input dcp_mode_e m,
                                     input logic d);
      dma_gate = (m == DCP_MODE_PS2) | d;
   endfunction : dma_gate

   function automatic logic map_hit(input logic [7:0] a);
      map_hit = (a == `DCP_OFS_MSR) | (a == `DCP_OFS_DATA) |
                (a == `DCP_OFS_DOR) | (a == `DCP_OFS_CFG);
   endfunction : map_hit

   always_comb begin
      nxt_st = nxt_calc();
   end

   // Next state of the whole block, one function for one process
   function automatic dcp_state_s nxt_calc();
      logic       push;
      logic       pop;
      logic [7:0] pd;
      logic [4:0] cap;
      logic [4:0] lvl;
      logic [4:0] thr1;
      logic       sect_end;
      dcp_state_s n;
      dcp_state_s k;
      dcp_state_s s;
      s        = st_ff;
      n        = st_ff;
      push     = 1'b0;
      pop      = 1'b0;
      pd       = 8'h00;
      sect_end = 1'b0;
      k        = ST_RST;
      cap      = fifo_cap(s.fifo_en);
      // R10: threshold plus one
      thr1     = s.fifo_en ? ({1'b0, s.thr} + 5'h01) : 5'h01;
      // FIFO off holds one byte, so one byte must raise the request
      lvl      = s.fifo_en ? (`DCP_FIFO_DEPTH - thr1) : 5'h01;
      if (lvl == 5'h00) begin
         lvl = 5'h01;
      end

      n.pready  = apb_acc & ~s.pready;
      n.pslverr = 1'b0;
      n.prdata  = 32'h0000_0000;
      if (apb_acc & ~s.pready) begin
         n.pslverr = ~map_hit(paddr);
         if (~pwrite) begin
            case (paddr)
               `DCP_OFS_MSR: begin
                  n.prdata[7:0] = {s.request_for_master_flag, s.transfer_direction_flag, 1'b0, s.busy,
                                   3'h0, s.int_pend};
               end
               `DCP_OFS_DATA: begin
                  if (s.phase == DCP_PH_RESULT) begin
                     n.prdata[7:0] = s.rbuf[s.ridx];
                  end
               end
               `DCP_OFS_DOR: begin
                  n.prdata[`DCP_DOR_RST] = s.dor_rst;
                  n.prdata[`DCP_DOR_DMA] = s.dor_dma;
                  n.prdata[`DCP_DOR_HD]  = s.dor_hd;
               end
               `DCP_OFS_CFG: begin
                  n.prdata[`DCP_CFG_BURST] = s.burst;
                  n.prdata[`DCP_CFG_MODE]  = s.mode;
               end
               default: begin
                  n.prdata = 32'h0000_0000;
               end
            endcase
         end
      end

      if (apb_take & pwrite) begin
         case (paddr)
            `DCP_OFS_DOR: begin
               // R25: core stays in reset while bit set
               n.dor_rst = pwdata[`DCP_DOR_RST];
               n.dor_dma = pwdata[`DCP_DOR_DMA];
               n.dor_hd  = pwdata[`DCP_DOR_HD];
            end
            `DCP_OFS_CFG: begin
               // R24: mode select bits
               n.burst = pwdata[`DCP_CFG_BURST];
               n.mode  = dcp_mode_e'(pwdata[`DCP_CFG_MODE]);
            end
            `DCP_OFS_DATA: begin
               // R06: request flag drops per byte
               if (s.request_for_master_flag & ~s.transfer_direction_flag & ~s.dor_rst) begin
                  n.lat  = pwdata[7:0];
                  n.request_for_master_flag  = 1'b0;
                  n.proc = 1'b1;
                  n.busy = 1'b1;
               end
            end
            default: begin
               n.lat = s.lat;
            end
         endcase
      end

      if (apb_take & ~pwrite & (paddr == `DCP_OFS_DATA) &
          (s.phase == DCP_PH_RESULT) & s.request_for_master_flag & s.transfer_direction_flag) begin
         n.ridx = s.ridx + 2'd1;
         if (s.ridx == s.rcnt) begin
            // R22: ready for a new command
            n.phase = DCP_PH_CMD;
            n.request_for_master_flag   = 1'b1;
            n.transfer_direction_flag   = 1'b0;
            n.busy  = 1'b0;
            n.int_pend = 1'b0;
         end
      end

      if (s.proc) begin
         n.proc = 1'b0;
         case (s.phase)
            DCP_PH_CMD: begin
               case (s.lat)
                  `DCP_CMD_SENSE: begin
                     n.rbuf[0]  = s.inv_pend ? `DCP_ST0_INV : s.st0;
                     n.rcnt     = 2'd0;
                     n.ridx     = 2'd0;
                     n.inv_pend = 1'b0;
                     n.int_pend = 1'b0;
                     n.phase    = DCP_PH_RESULT;
                     n.request_for_master_flag      = 1'b1;
                     n.transfer_direction_flag      = 1'b1;
                  end
                  `DCP_CMD_SPEC, `DCP_CMD_CONF,
                  `DCP_CMD_READ, `DCP_CMD_WRITE: begin
                     // R04: parameters follow the opcode
                     n.cmd   = s.lat;
                     n.pidx  = 1'b0;
                     n.phase = DCP_PH_PARAM;
                     n.request_for_master_flag   = 1'b1;
                  end
                  default: begin
                     // R23: invalid opcode flagged
                     n.inv_pend = 1'b1;
                     n.int_pend = 1'b1;
                     n.request_for_master_flag      = 1'b1;
                     n.busy     = 1'b0;
                  end
               endcase
            end
            DCP_PH_PARAM: begin
               n.request_for_master_flag   = 1'b1;
               n.busy  = 1'b0;
               n.phase = DCP_PH_CMD;
               case (s.cmd)
                  `DCP_CMD_SPEC: begin
                     // R03: DMA enable from Specify
                     n.dma_spec = ~s.lat[0];
                  end
                  `DCP_CMD_CONF: begin
                     // R09: Configure enables the FIFO when bit 5 is clear and sets the threshold
                     n.fifo_en = ~s.lat[`DCP_CNF_NOFIFO];
                     n.thr     = s.lat[3:0];
                  end
                  default: begin
                     n.busy  = 1'b1;
                     n.phase = DCP_PH_PARAM;
                     n.pidx  = 1'b1;
                     if (~s.pidx) begin
                        n.sector = s.lat;
                     end else begin
                        // R07: last parameter starts execution
                        n.request_for_master_flag     = 1'b0;
                        n.last_sector_number     = s.lat;
                        n.phase   = DCP_PH_EXEC;
                        n.dir_wr  = (s.cmd == `DCP_CMD_WRITE);
                        n.bcnt    = 8'h00;
                        n.xfer_on = 1'b1;
                        n.tc_seen = 1'b0;
                        n.ovr     = 1'b0;
                        n.abn     = 1'b0;
                        n.pad     = 1'b0;
                        n.rd_last = 1'b0;
                        // R14: write request on entry
                        n.arm     = (s.cmd == `DCP_CMD_WRITE);
                     end
                  end
               endcase
            end
            default: begin
               n.proc = 1'b0;
            end
         endcase
      end

      if (s.phase == DCP_PH_EXEC) begin
         // R16: terminal count stops requests
         if (transfer_end_strobe) begin
            n.tc_seen = 1'b1;
         end
         if (~s.dir_wr) begin
            if (disk_rd_valid & s.xfer_on) begin
               if (s.tc_seen | s.ovr) begin
                  push = 1'b0;
               end else if (s.fcnt >= cap) begin
                  // R17: overrun ends implicitly
                  n.ovr = 1'b1;
                  n.abn = 1'b1;
               end else begin
                  push = 1'b1;
                  pd   = disk_rd_data;
               end
               n.bcnt   = s.bcnt + 8'h01;
               sect_end = (s.bcnt == `DCP_SECT_LAST);
            end
            // R13: DMA reads drain the FIFO
            if (dma_ack & (s.fcnt != 5'h00) & ~s.tc_seen) begin
               pop = 1'b1;
            end
         end else begin
            // R11: write data arrives by DMA only
            if (dma_ack & (s.fcnt < cap) & ~s.tc_seen) begin
               push = 1'b1;
               pd   = dma_wdata;
            end
            if (disk_wr_take & s.xfer_on) begin
               if (s.fcnt != 5'h00) begin
                  pop = 1'b1;
               end else if (~s.tc_seen & ~s.pad) begin
                  // R18: underrun pads the sector
                  n.ovr = 1'b1;
                  n.abn = 1'b1;
                  n.pad = 1'b1;
               end
               n.bcnt   = s.bcnt + 8'h01;
               sect_end = (s.bcnt == `DCP_SECT_LAST);
            end
         end
         if (sect_end) begin
            n.bcnt = 8'h00;
            // R17: end on count, error or last sector
            if (n.ovr | (s.tc_seen & ~(s.dir_wr & (s.fcnt > 5'h01))) |
                (s.sector == s.last_sector_number)) begin
               n.xfer_on = 1'b0;
               n.rd_last = 1'b1;
               if (~s.tc_seen & ~n.ovr) begin
                  n.abn = 1'b1;
               end
            end else begin
               n.sector = s.sector + 8'h01;
               n.pad    = 1'b0;
            end
         end
      end

      if (push) begin
         n.mem[s.wp] = pd;
         n.wp = s.wp + 4'h1;
      end
      if (pop) begin
         n.rp = s.rp + 4'h1;
      end
      n.fcnt = s.fcnt + {4'h0, push} - {4'h0, pop};
      if ((s.phase == DCP_PH_EXEC) & ~s.dir_wr & n.tc_seen) begin
         n.fcnt = 5'h00;
         n.rp   = n.wp;
      end

      if (s.phase == DCP_PH_EXEC) begin
         if (~s.dir_wr) begin
            // R12: read request at level or at the sector end that ends the transfer
            if ((n.fcnt >= lvl) | (n.rd_last & (n.fcnt != 5'h00))) begin
               n.arm = 1'b1;
            end
            if (n.fcnt == 5'h00) begin
               n.arm = 1'b0;
            end
         end else begin
            // R15: re-request on free space
            if (n.fcnt >= cap) begin
               n.arm = 1'b0;
            end else if ((cap - n.fcnt) >= thr1) begin
               n.arm = 1'b1;
            end
         end
         // Read side keeps requesting after sector end to drain
         if (n.tc_seen | (~n.xfer_on & s.dir_wr)) begin
            n.arm = 1'b0;
         end
         if (~n.xfer_on & (n.fcnt == 5'h00)) begin
            // R20: result phase opens with interrupt
            n.phase    = DCP_PH_RESULT;
            n.st0      = n.abn ? `DCP_ST0_ABN : 8'h00;
            n.rbuf[0]  = n.st0;
            n.rbuf[1]  = {n.abn & ~n.ovr, 2'b00, n.ovr, 4'h0};
            n.rbuf[2]  = s.sector;
            n.rcnt     = 2'd2;
            n.ridx     = 2'd0;
            n.request_for_master_flag      = 1'b1;
            n.transfer_direction_flag      = 1'b1;
            n.int_pend = 1'b1;
            n.arm      = 1'b0;
         end
      end

      if (n.dor_rst) begin
         // R25: core cleared, DOR, mode, burst and Specify DMA settings kept
         k.dor_rst  = 1'b1;
         k.dor_dma  = n.dor_dma;
         k.dor_hd   = n.dor_hd;
         k.mode     = n.mode;
         k.burst    = n.burst;
         k.dma_spec = n.dma_spec;
         k.pready   = n.pready;
         k.pslverr  = n.pslverr;
         k.prdata   = n.prdata;
         n = k;
      end else if (s.dor_rst) begin
         // R04: command phase after reset
         n.request_for_master_flag = 1'b1;
      end

      // R08: FIFO flushed outside execution
      if (n.phase != DCP_PH_EXEC) begin
         n.fcnt = 5'h00;
         n.rp   = n.wp;
      end

      // R02: single mode gaps after each byte
      n.gap = ~n.burst & dma_ack & s.dma_req;
      // R01: mode gates DMA and interrupt
      n.dma_req = n.arm & n.dma_spec & ~n.gap &
                  (n.phase == DCP_PH_EXEC) &
                  dma_gate(n.mode, n.dor_dma);
      n.int_req = n.int_pend & dma_gate(n.mode, n.dor_dma);
      n.dens = (n.mode == DCP_MODE_AT) ? n.dor_hd : ~n.dor_hd;
      n.dma_rdata = n.mem[n.rp];
      n.wr_data = (n.fcnt != 5'h00) ? n.mem[n.rp] : 8'h00;
      return n;
   endfunction : nxt_calc

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata         = st_ff.prdata;
   assign pready         = st_ff.pready;
   assign pslverr        = st_ff.pslverr;
   assign dma_req        = st_ff.dma_req;
   assign dma_rdata      = st_ff.dma_rdata;
   assign int_req        = st_ff.int_req;
   assign density_select = st_ff.dens;
   assign disk_rd_active = (st_ff.phase == DCP_PH_EXEC) &
                           ~st_ff.dir_wr & st_ff.xfer_on;
   assign disk_wr_active = (st_ff.phase == DCP_PH_EXEC) &
                           st_ff.dir_wr & st_ff.xfer_on;
   assign disk_wr_data   = st_ff.wr_data;

   sequence s_data_wr;
      apb_take & pwrite & (paddr == `DCP_OFS_DATA) &
      st_ff.request_for_master_flag & ~st_ff.transfer_direction_flag & ~st_ff.dor_rst;
   endsequence

   sequence s_last_res;
      apb_take & ~pwrite & (paddr == `DCP_OFS_DATA) &
      (st_ff.phase == DCP_PH_RESULT) & st_ff.request_for_master_flag &
      st_ff.transfer_direction_flag & (st_ff.ridx == st_ff.rcnt);
   endsequence

   property p_gate;
      @(posedge pclk) disable iff (!presetn)
      dma_req |-> (st_ff.mode == DCP_MODE_PS2) | st_ff.dor_dma;
   endproperty
   a_gate: assert property (p_gate) // R01
      else $error("DMA request while gated off");

   property p_dens;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.mode == DCP_MODE_M30) |-> density_select == ~st_ff.dor_hd;
   endproperty
   a_dens: assert property (p_dens) // R01
      else $error("density select polarity wrong");

   property p_single;
      @(posedge pclk) disable iff (!presetn)
      ~st_ff.burst & dma_ack & dma_req |=> ~dma_req;
   endproperty
   a_single: assert property (p_single) // R02
      else $error("single mode request not dropped");

   property p_rst_cmd;
      @(posedge pclk) disable iff (!presetn)
      $fell(st_ff.dor_rst) |-> (st_ff.phase == DCP_PH_CMD) &
                               st_ff.request_for_master_flag & ~st_ff.transfer_direction_flag;
   endproperty
   a_rst_cmd: assert property (p_rst_cmd) // R04
      else $error("not in command phase after reset");

   property p_rqm_drop;
      @(posedge pclk) disable iff (!presetn)
      s_data_wr |=> ~st_ff.request_for_master_flag ##1 ~st_ff.proc;
   endproperty
   a_rqm_drop: assert property (p_rqm_drop) // R06
      else $error("request flag not dropped after write");

   property p_fifo_cmd;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.phase != DCP_PH_EXEC) |-> st_ff.fcnt == 5'h00;
   endproperty
   a_fifo_cmd: assert property (p_fifo_cmd) // R08
      else $error("FIFO holds data outside execution");

   property p_rd_empty;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.phase == DCP_PH_EXEC) & ~st_ff.dir_wr &
      (st_ff.fcnt == 5'h00) |-> ~dma_req;
   endproperty
   a_rd_empty: assert property (p_rd_empty) // R13
      else $error("read request with empty FIFO");

   property p_wr_full;
      @(posedge pclk) disable iff (!presetn)
      (st_ff.phase == DCP_PH_EXEC) & st_ff.dir_wr &
      (st_ff.fcnt >= fifo_cap(st_ff.fifo_en)) |-> ~dma_req;
   endproperty
   a_wr_full: assert property (p_wr_full) // R14
      else $error("write request with full FIFO");

   property p_tc;
      @(posedge pclk) disable iff (!presetn)
      transfer_end_strobe & (st_ff.phase == DCP_PH_EXEC) |=>
      ~dma_req [*2];
   endproperty
   a_tc: assert property (p_tc) // R16
      else $error("request after terminal count");

   property p_res_end;
      @(posedge pclk) disable iff (!presetn)
      s_last_res |=> st_ff.request_for_master_flag & ~st_ff.transfer_direction_flag & ~st_ff.busy;
   endproperty
   a_res_end: assert property (p_res_end) // R22
      else $error("flags wrong after last result");

endmodule : dcp_top
`default_nettype wire

// ===== dummy_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== dcp_dma_model.sv
// Purpose: DMA controller model on the far side of the block
// Assumes: one byte per dma_ack pulse
// Notes: slow mode acks only every fourth cycle
`timescale 1ns/1ps
`default_nettype none
module dcp_dma_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       slow,
   input  wire logic       dma_req,
   input  wire logic [7:0] dma_rdata,
   output logic            dma_ack,
   output logic      [7:0] dma_wdata,
   output logic            got,
   output logic      [7:0] got_data
);
   logic [1:0] cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dma_ack   <= 1'b0;
         dma_wdata <= 8'h00;
         got       <= 1'b0;
         got_data  <= 8'h00;
         cnt       <= 2'h0;
      end else begin
         cnt       <= cnt + 2'h1;
         dma_wdata <= ~dma_wdata;
         dma_ack   <= dma_req && !dma_ack && (!slow || cnt == 2'h3);
         got       <= dma_ack && dma_req;
         got_data  <= dma_rdata;
      end
   end
endmodule : dcp_dma_model
`default_nettype wire

// ===== test_disk_ctrl_phase_dma_fifo.sv
// Purpose: self-checking bench of the phase and DMA FIFO block
// Assumes: APB master, DMA model, disk byte source
// Notes: disk read with FIFO off and on, invalid command
`include "dcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module test_disk_ctrl_phase_dma_fifo;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
   logic [7:0] paddr, dma_rdata, dma_wdata, disk_rd_data, gd, b;
   logic [31:0] pwdata, prdata, r;
   logic dma_req, dma_ack, int_req, rd_act, rdv, got, e, dens, tcs;
   logic [7:0] exp_q[$];
   int fails, checks, cyc;
   dcp_top u_dcp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dma_req(dma_req), .dma_ack(dma_ack), .dma_wdata(dma_wdata),
      .dma_rdata(dma_rdata), .transfer_end_strobe(tcs),
      .int_req(int_req), .density_select(dens), .disk_rd_valid(rdv),
      .disk_rd_data(disk_rd_data), .disk_rd_active(rd_act),
      .disk_wr_active(), .disk_wr_take(1'b0), .disk_wr_data());
   dcp_dma_model u_dcp_dma_model (.pclk(pclk), .presetn(presetn),
      .slow(slow), .dma_req(dma_req), .dma_rdata(dma_rdata),
      .dma_ack(dma_ack), .dma_wdata(dma_wdata), .got(got), .got_data(gd));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk
   task close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   always @(posedge pclk) begin
      cyc++;
      if (got)
         chk(gd, exp_q.pop_front());
      if (cyc == 60000) begin
         fails++;
         close_out;
      end
   end
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic poll(input logic [1:0] want);
      do apb(1'b0, `DCP_OFS_MSR, 0); while (r[7:6] !== want);
   endtask : poll
   task automatic wr_byte(input logic [7:0] v);
      poll(2'b10);
      apb(1'b1, `DCP_OFS_DATA, {24'h0, v});
   endtask : wr_byte
   task automatic rd_res();
      poll(2'b11);
      apb(1'b0, `DCP_OFS_DATA, 0);
   endtask : rd_res
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, rdv, slow, tcs} = '0;
      disk_rd_data = 8'h00;
      void'($urandom(32'h7C24));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `DCP_OFS_MSR, 0);
      chk(r, 32'h0);
      apb(1'b1, `DCP_OFS_DOR, 32'h28);
      apb(1'b0, `DCP_OFS_MSR, 0);
      chk(r[7:6], 2'b10);
      chk(dens, 1'b1);
      apb(1'b0, 8'h40, 0);
      chk(e, 1'b1);
      $display("test reset done");
      wr_byte(8'hFF);
      repeat (4) @(posedge pclk);
      apb(1'b0, `DCP_OFS_MSR, 0);
      chk({r[7:6], r[0]}, 3'b101);
      wr_byte(`DCP_CMD_SENSE);
      rd_res();
      chk(r, `DCP_ST0_INV);
      apb(1'b0, `DCP_OFS_MSR, 0);
      chk({r[7:6], r[4]}, 3'b100);
      $display("test invalid done");
      for (int k = 0; k < 3; k++) begin
         if (k == 1) begin
            wr_byte(`DCP_CMD_CONF);
            wr_byte(8'($urandom % 16));
         end
         slow <= 1'($urandom);
         apb(1'b1, `DCP_OFS_CFG, $urandom & 32'h2);
         wr_byte(`DCP_CMD_READ);
         wr_byte(8'h01);
         wr_byte(8'h01);
         apb(1'b0, `DCP_OFS_MSR, 0);
         chk(r[7], 1'b0);
         for (int i = 0; i < 128; i++) begin
            while (rd_act !== 1'b1) @(posedge pclk);
            b = 8'($urandom);
            if (k != 2 || i < 64)
               exp_q.push_back(b);
            rdv <= 1'b1;
            tcs <= (k == 2 && i == 64);
            disk_rd_data <= b;
            @(posedge pclk);
            rdv <= 1'b0;
            tcs <= 1'b0;
            repeat (7) @(posedge pclk);
         end
         rd_res();
         chk(int_req, 1'b1);
         chk(r[7:0] & 8'hC0, (k == 2) ? 8'h00 : `DCP_ST0_ABN);
         rd_res();
         chk(r[7], k != 2);
         rd_res();
         chk(r, 32'h1);
         chk(exp_q.size() <= ((k == 2) ? 16 : 0), 1'b1);
         exp_q.delete();
         apb(1'b0, `DCP_OFS_MSR, 0);
         chk({r[7:6], r[4]}, 3'b100);
         $display("test read %0d done", k);
      end
      close_out;
   end
endmodule : test_disk_ctrl_phase_dma_fifo
`default_nettype wire
